// ==== inc/mps_pkg.sv ====
// package of constants and types shared by both ends of the power sequencer
package mps_pkg;
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned STAB_MS = 5;
    localparam int unsigned STAB_CYC = (STAB_MS * CLK_HZ + 999) / 1000;
    localparam int unsigned PIN_W = 8;
    localparam logic [PIN_W-1:0] PINS_OFF = 8'h00;
    localparam logic [PIN_W-1:0] PINS_ON = 8'hFF;

    typedef enum logic [2:0] {
        MPS_H_OFF = 3'b000,
        MPS_H_WAIT_IO = 3'b001,
        MPS_H_STAB = 3'b010,
        MPS_H_RUN = 3'b011
    } mps_host_t;

    typedef enum logic [2:0] {
        MPS_D_DOWN = 3'b000,
        MPS_D_PORST = 3'b001,
        MPS_D_DEFAULT = 3'b010,
        MPS_D_DOZE = 3'b011,
        MPS_D_ACTIVE = 3'b100
    } mps_dev_t;
endpackage

// ==== inc/mps_if.sv ====
// interface joining host sequencer and device power control
`timescale 1ns/100ps
interface mps_if;
    logic moduleEnable;
    logic hardResetPinLow_n;
    logic ioSupplyRail;
    modport host (output moduleEnable, output hardResetPinLow_n, input ioSupplyRail);
    modport dev (input moduleEnable, input hardResetPinLow_n, input ioSupplyRail);
endinterface

// ==== logic/mps_device.sv ====
// device end: power states, dc/dc control and digital pin states
`timescale 1ns/100ps
module mps_device
    import mps_pkg::*;
#(
    parameter int unsigned PW = PIN_W
) (
    input wire logic clk_sys,
    input wire logic hard_reset_pin_low,
    mps_if.dev link,
    input wire logic cfgDone,
    input wire logic [PW-1:0] cfgOutEn,
    input wire logic [PW-1:0] cfgPullEn,
    input wire logic wifiReq,
    input wire logic btReq,
    output logic dcdcOn,
    output logic [PW-1:0] pinOutEn,
    output logic [PW-1:0] pinInEn,
    output logic [PW-1:0] pinPullEn,
    output logic wifiActive,
    output logic btActive,
    output mps_dev_t devState
);
    // ----------------------------------------
    // pin phase decoding
    // ----------------------------------------
    // output drivers: hi-z until firmware owns the pins
    function automatic logic [PW-1:0] outMask(mps_dev_t st, logic [PW-1:0] progOut);
        logic [PW-1:0] mask;
        unique case (st)
            MPS_D_DOWN: mask = PINS_OFF;
            MPS_D_PORST: mask = PINS_OFF;
            MPS_D_DEFAULT: mask = PINS_OFF;
            MPS_D_DOZE, MPS_D_ACTIVE: mask = progOut;
            default: mask = PINS_OFF;
        endcase
        return mask;
    endfunction

    // input buffers: on from reset release, then the inverse of the driver
    function automatic logic [PW-1:0] inMask(mps_dev_t st, logic [PW-1:0] progOut);
        logic [PW-1:0] mask;
        unique case (st)
            MPS_D_DOWN: mask = PINS_OFF;
            MPS_D_PORST: mask = PINS_OFF;
            MPS_D_DEFAULT: mask = PINS_ON;
            MPS_D_DOZE, MPS_D_ACTIVE: mask = ~progOut;
            default: mask = PINS_OFF;
        endcase
        return mask;
    endfunction

    // pulls: on from enable onward, firmware setting once programmed
    function automatic logic [PW-1:0] pullMask(mps_dev_t st, logic [PW-1:0] progPull);
        logic [PW-1:0] mask;
        unique case (st)
            MPS_D_DOWN: mask = PINS_OFF;
            MPS_D_PORST: mask = PINS_ON;
            MPS_D_DEFAULT: mask = PINS_ON;
            MPS_D_DOZE, MPS_D_ACTIVE: mask = progPull;
            default: mask = PINS_OFF;
        endcase
        return mask;
    endfunction

    // a radio runs only while its own request stands in the active state
    function automatic logic radioOn(mps_dev_t st, logic req);
        return (st == MPS_D_ACTIVE) && req;
    endfunction

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    logic [2:0] syncA_reg;
    logic [2:0] syncB_reg;
    // first stage may go metastable; only the second stage reads it
    always_ff @(posedge clk_sys or negedge hard_reset_pin_low) begin
        if (!hard_reset_pin_low) begin
            syncA_reg <= 3'h0;
        end else begin
            syncA_reg <= {link.ioSupplyRail, link.moduleEnable, link.hardResetPinLow_n};
        end
    end

    always_ff @(posedge clk_sys or negedge hard_reset_pin_low) begin
        if (!hard_reset_pin_low) begin
            syncB_reg <= 3'h0;
        end else begin
            syncB_reg <= syncA_reg;
        end
    end
    wire ioUp = syncB_reg[2];
    wire enHi = syncB_reg[1];
    wire rstHi = syncB_reg[0];

    // ----------------------------------------
    // state selection
    // ----------------------------------------
    mps_dev_t state_reg;
    mps_dev_t state_next;
    wire coreOn = ioUp && enHi;
    wire anyRadio = wifiReq || btReq;
    always_comb begin
        state_next = state_reg;
        if (!coreOn || !rstHi) begin
            state_next = coreOn ? MPS_D_PORST : MPS_D_DOWN;
        end else begin
            unique case (state_reg)
                MPS_D_DOWN, MPS_D_PORST: state_next = MPS_D_DEFAULT;
                MPS_D_DEFAULT: state_next = cfgDone ? MPS_D_DOZE : MPS_D_DEFAULT;
                MPS_D_DOZE, MPS_D_ACTIVE: state_next = anyRadio ? MPS_D_ACTIVE : MPS_D_DOZE;
                default: state_next = MPS_D_DOWN;
            endcase
        end
    end

    // next pin states follow the state being entered
    wire [PW-1:0] outNext = outMask(state_next, cfgOutEn);
    wire [PW-1:0] inNext = inMask(state_next, cfgOutEn);
    wire [PW-1:0] pullNext = pullMask(state_next, cfgPullEn);
    wire wifiNext = radioOn(state_next, wifiReq);
    wire btNext = radioOn(state_next, btReq);

    // ----------------------------------------
    // state register
    // ----------------------------------------
    // pin and radio controls decode the state being entered, not this one
    always_ff @(posedge clk_sys or negedge hard_reset_pin_low) begin
        if (!hard_reset_pin_low) begin
            state_reg <= MPS_D_DOWN;
        end else begin
            state_reg <= state_next;
        end
    end
    assign devState = state_reg;

    // ----------------------------------------
    // dc/dc converter control
    // ----------------------------------------
    // converter needs both the io rail and the enable pin
    always_ff @(posedge clk_sys or negedge hard_reset_pin_low) begin
        if (!hard_reset_pin_low) begin
            dcdcOn <= 1'b0;
        end else begin
            dcdcOn <= coreOn;
        end
    end

    // ----------------------------------------
    // pin driver, input buffer and pull controls
    // ----------------------------------------
    // all registered so pins never glitch between phases
    // drivers stay hi-z outside the programmed phase
    always_ff @(posedge clk_sys or negedge hard_reset_pin_low) begin
        if (!hard_reset_pin_low) begin
            pinOutEn <= PINS_OFF;
        end else begin
            pinOutEn <= outNext;
        end
    end

    // input buffer is the inverse of the driver once programmed
    always_ff @(posedge clk_sys or negedge hard_reset_pin_low) begin
        if (!hard_reset_pin_low) begin
            pinInEn <= PINS_OFF;
        end else begin
            pinInEn <= inNext;
        end
    end

    // pulls come up with the enable, before reset release
    always_ff @(posedge clk_sys or negedge hard_reset_pin_low) begin
        if (!hard_reset_pin_low) begin
            pinPullEn <= PINS_OFF;
        end else begin
            pinPullEn <= pullNext;
        end
    end

    // ----------------------------------------
    // radio activity
    // ----------------------------------------
    // each radio follows its own request; both may run at once
    always_ff @(posedge clk_sys or negedge hard_reset_pin_low) begin
        if (!hard_reset_pin_low) begin
            wifiActive <= 1'b0;
            btActive <= 1'b0;
        end else begin
            wifiActive <= wifiNext;
            btActive <= btNext;
        end
    end
endmodule

// ==== logic/mps_host.sv ====
// host end: drives enable and reset pins in the required order
`timescale 1ns/100ps
module mps_host
    import mps_pkg::*;
#(
    parameter int unsigned STAB_CYCLES = STAB_CYC
) (
    input wire logic clk_sys,
    input wire logic hard_reset_pin_low,
    mps_if.host link,
    input wire logic powerReq,
    output logic powerGood
);
    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    logic [1:0] ioSync_reg;
    mps_host_t state_reg;
    mps_host_t state_next;
    logic [31:0] cnt_reg;
    logic en_reg;
    logic rst_n_reg;
    wire ioUp = ioSync_reg[1];
    wire goDown = !powerReq || !ioUp;
    wire cntDone = cnt_reg >= STAB_CYCLES - 1;
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            MPS_H_OFF: state_next = powerReq ? MPS_H_WAIT_IO : MPS_H_OFF;
            MPS_H_WAIT_IO: begin
                if (!powerReq) state_next = MPS_H_OFF;
                else if (ioUp) state_next = MPS_H_STAB;
            end
            MPS_H_STAB: begin
                if (goDown) state_next = MPS_H_OFF;
                else if (cntDone) state_next = MPS_H_RUN;
            end
            MPS_H_RUN: state_next = goDown ? MPS_H_OFF : MPS_H_RUN;
            default: state_next = MPS_H_OFF;
        endcase
    end
    wire enNext = (state_next == MPS_H_STAB) || (state_next == MPS_H_RUN);
    wire rstNext = state_next == MPS_H_RUN;
    always_ff @(posedge clk_sys or negedge hard_reset_pin_low) begin
        if (!hard_reset_pin_low) begin
            ioSync_reg <= 2'h0;
            state_reg <= MPS_H_OFF;
            cnt_reg <= 32'h0;
            en_reg <= 1'b0;
            rst_n_reg <= 1'b0;
        end else begin
            ioSync_reg <= {ioSync_reg[0], link.ioSupplyRail};
            state_reg <= state_next;
            cnt_reg <= (state_reg == MPS_H_STAB) ? cnt_reg + 32'h1 : 32'h0;
            en_reg <= enNext;
            rst_n_reg <= rstNext;
        end
    end
    assign link.moduleEnable = en_reg;
    assign link.hardResetPinLow_n = rst_n_reg;
    assign powerGood = rst_n_reg;
endmodule

// ==== test/mps_seq_properties.sv ====
// wire checks on enable, reset and io rail between host and device
`timescale 1ns/100ps
module mps_seq_properties
    import mps_pkg::*;
#(
    parameter int unsigned STAB_CYCLES = STAB_CYC
) (
    input wire logic clk_sys,
    input wire logic hard_reset_pin_low,
    input wire logic moduleEnable,
    input wire logic hardResetPinLow_n,
    input wire logic ioSupplyRail
);
    logic [31:0] hold_reg;
    wire [31:0] hold_next = (moduleEnable && !hardResetPinLow_n) ? hold_reg + 32'h1 : 32'h0;
    always_ff @(posedge clk_sys or negedge hard_reset_pin_low) begin
        if (!hard_reset_pin_low) begin
            hold_reg <= 32'h0;
        end else begin
            hold_reg <= hold_next;
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!hard_reset_pin_low);
    en_after_rail_a: assert property ($rose(moduleEnable) |-> $past(ioSupplyRail, 2))
        else $error("enable rose without io rail");
    reset_hold_a: assert property ($rose(hardResetPinLow_n) |-> hold_reg >= STAB_CYCLES)
        else $error("reset released too early");
    reset_early_a: assert property ($rose(moduleEnable) |-> !hardResetPinLow_n [*8])
        else $error("reset not held after enable");
    reset_needs_en_a: assert property (hardResetPinLow_n |-> moduleEnable)
        else $error("reset high with enable low");
    fall_pair_a: assert property ($fell(hardResetPinLow_n) |-> $fell(moduleEnable))
        else $error("reset fell alone");
    en_fall_low_a: assert property ($fell(moduleEnable) |-> !hardResetPinLow_n)
        else $error("enable fell with reset high");
    rail_drop_a: assert property ($fell(ioSupplyRail) |-> ##[1:4] !moduleEnable)
        else $error("pins still high after rail drop");
    rail_off_a: assert property (!ioSupplyRail [*5] |-> !moduleEnable)
        else $error("enable high while rail off");
    cover property ($rose(hardResetPinLow_n));
    cover property ($fell(moduleEnable));
    cover property ($fell(ioSupplyRail));
endmodule

// ==== test/test_module_power_sequencing.sv ====
// self-checking bench with host and device joined by the link
`timescale 1ns/100ps
module test_module_power_sequencing;
    import mps_pkg::*;
    localparam int ST = 20;
    logic clk_sys = 0, hard_reset_pin_low = 0, powerReq = 0, cfgDone = 0, wifiReq = 0, btReq = 0;
    logic [7:0] cfgOutEn = 8'h00, cfgPullEn = 8'h00, pinOutEn, pinInEn, pinPullEn;
    logic dcdcOn, powerGood, wifiActive, btActive;
    mps_dev_t devState;
    int failures = 0, numChecks = 0, seed = 91, cyc = 0;
    mps_if link();
    mps_host #(.STAB_CYCLES(ST)) i_mps_host(.clk_sys(clk_sys), .hard_reset_pin_low(hard_reset_pin_low), .link(link),
        .powerReq(powerReq), .powerGood(powerGood));
    mps_device i_mps_device(.clk_sys(clk_sys), .hard_reset_pin_low(hard_reset_pin_low), .link(link), .cfgDone(cfgDone),
        .cfgOutEn(cfgOutEn), .cfgPullEn(cfgPullEn), .wifiReq(wifiReq), .btReq(btReq),
        .dcdcOn(dcdcOn), .pinOutEn(pinOutEn), .pinInEn(pinInEn), .pinPullEn(pinPullEn),
        .wifiActive(wifiActive), .btActive(btActive), .devState(devState));
    mps_seq_properties #(.STAB_CYCLES(ST)) i_mps_seq_properties(.clk_sys(clk_sys),
        .hard_reset_pin_low(hard_reset_pin_low), .moduleEnable(link.moduleEnable),
        .hardResetPinLow_n(link.hardResetPinLow_n), .ioSupplyRail(link.ioSupplyRail));
    task automatic chk(logic [7:0] seen, logic [7:0] exp);
        numChecks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    function automatic mps_dev_t expSt(logic w, logic b);
        return (w | b) ? MPS_D_ACTIVE : MPS_D_DOZE;
    endfunction
    task automatic results();
        $display("checks=%0d failures=%0d", numChecks, failures);
        if (failures == 0 && numChecks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always #50 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            results();
        end
    end
    initial begin
        link.ioSupplyRail = 1'b1;
        step(4);
        hard_reset_pin_low = 1'b1;
        step(1);
        chk($isunknown({link.moduleEnable, link.hardResetPinLow_n}), 0);
        chk({dcdcOn, powerGood, devState}, MPS_D_DOWN);
        chk(pinOutEn | pinInEn | pinPullEn, PINS_OFF);
        powerReq = 1'b1;
        for (int i = 0; i < 10 && link.moduleEnable !== 1'b1; i++)
            step(1);
        chk(link.moduleEnable, 1);
        step(4);
        chk(dcdcOn, 1);
        chk(pinPullEn, PINS_ON);
        chk(pinInEn | pinOutEn, PINS_OFF);
        step(ST - 5);
        chk(link.hardResetPinLow_n, 0);
        step(1);
        chk({link.hardResetPinLow_n, powerGood}, 3);
        step(4);
        chk(devState, MPS_D_DEFAULT);
        chk(pinInEn & ~pinOutEn, PINS_ON);
        for (int i = 0; i < 6; i++) begin
            cfgOutEn = (i == 0) ? 8'hFF : 8'($random(seed));
            cfgPullEn = 8'($random(seed));
            {wifiReq, btReq} = (i < 4) ? i[1:0] : 2'($random(seed));
            cfgDone = 1'b1;
            step(5);
            chk(pinOutEn, cfgOutEn);
            chk(pinInEn, ~cfgOutEn);
            chk(pinPullEn, cfgPullEn);
            chk(devState, expSt(wifiReq, btReq));
            chk({wifiActive, btActive}, {wifiReq, btReq});
        end
        powerReq = 1'b0;
        step(3);
        chk({link.moduleEnable, link.hardResetPinLow_n}, 0);
        step(4);
        chk({dcdcOn, devState}, MPS_D_DOWN);
        chk(pinOutEn | pinInEn | pinPullEn, PINS_OFF);
        powerReq = 1'b1;
        step(ST);
        chk(devState, MPS_D_PORST);
        step(8);
        chk({powerGood, devState}, {1'b1, expSt(wifiReq, btReq)});
        link.ioSupplyRail = 1'b0;
        step(5);
        chk({link.moduleEnable, link.hardResetPinLow_n}, 0);
        step(20);
        chk(link.moduleEnable, 0);
        chk($isunknown({link.moduleEnable, link.hardResetPinLow_n}), 0);
        results();
    end
endmodule
